// ---- ctagc_bank.sv ----
// Purpose: configuration bank for converter clocks, power-down, test DAC mux and gain set-up
// Assumes: APB slave with zero wait states; AGC logic and converters on clk
// Notes: pin inputs pass two flip-flops before use
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - clock-source bit chooses internal clocks or the serial input pin for converters.
// - seven clock gates, 0 enables and 1 disables, bits 6 down to 0.
// - manual bit chooses power-down drive from registers or reset and power enables.
// - under manual control each bit 7..1 asserts its power-down signal when 1.
// - format bit gives two's complement when 0, offset binary when 1.
// - select codes 000..011 route filter, down-converter, chip timing or A/D samples.
// - codes 100..111 route winners, matched-filter weights, test bus, correlator/low-rate.
// - RF A/D into RX DAC wins; test bus into DACs only when it is off.
// - attenuator accumulator held between zero and the programmed gain clip.
// - mid and low saturation counts in upper and lower nibble set step use.
// - six-bit RF pad value in dB feeds the signal strength calculation.
// - saturations above high count apply twice the programmed high step.
// - tone detector scale; zero forces active, all ones forces inactive.
// - five-bit inner lock-in window in half steps.
// - diversity search allowed when lock updates do not exceed the maximum.
// - five-bit positive outer lock window.
// - six-bit backoff in half-dB sets converter headroom.
// - table-read bit makes data register reads return the table entry.
// - unused bits are stored and read back; software writes them zero.
// - table data register holds an unsigned seven-bit entry.
// - test-mode bit turns the test bus pins into inputs.
// - bit 7 of the test register picks correlator or low-rate samples for code 111.
module ctagc_bank (
	input wire logic clk,
	input wire logic nrst,
	input wire ctagc_pkg::ctagc_apb_req_type apb_req,
	output ctagc_pkg::ctagc_apb_rsp_type apb_rsp,
	input wire logic transmit_power_enable,
	input wire logic receive_power_enable,
	input wire ctagc_pkg::ctagc_taps_type taps,
	input wire logic [5:0] adc_i_raw,
	input wire logic [5:0] adc_q_raw,
	input wire logic [5:0] adc_rf_raw,
	input wire logic [6:0] rx_dac_normal,
	input wire logic [6:0] tx_dac_normal,
	input wire logic [5:0] test_bus_in,
	input wire logic [5:0] test_bus_drive,
	input wire logic [8:0] atten_req,
	input wire logic [4:0] sat_count,
	input wire logic [2:0] lock_updates,
	input wire logic [4:0] table_rd_addr,
	output logic conv_clk_from_serial_pin,
	output logic [6:0] conv_clk_gate_off,
	output ctagc_pkg::ctagc_pd_type power_down,
	output logic [5:0] adc_i_out,
	output logic [5:0] adc_q_out,
	output logic [5:0] adc_rf_out,
	output logic [5:0] iq_dac_i,
	output logic [5:0] iq_dac_q,
	output logic [6:0] rx_dac,
	output logic [6:0] tx_dac,
	output logic [5:0] test_bus_out,
	output logic test_bus_oe_n,
	output logic ref_trim_high,
	output logic ref_trim_low,
	output ctagc_pkg::ctagc_agc_cfg_type agc_cfg,
	output logic [6:0] atten_acc,
	output logic hi_step_apply,
	output logic mid_step_apply,
	output logic low_step_apply,
	output logic diversity_allowed,
	output logic [6:0] table_rd_data
);
	import ctagc_pkg::*;

	typedef struct packed {
		logic [7:0] clk_gate;
		logic [7:0] pd_ovr;
		logic [7:0] fmt_mux;
		logic [7:0] gain_clip;
		logic [7:0] sat_thr;
		logic [7:0] rf_pad;
		logic [7:0] hi_sat;
		logic [7:0] lock_in;
		logic [7:0] lock_pos;
		logic [7:0] backoff;
		logic [7:0] tbl_addr;
		logic [7:0] tbl_data;
		logic [7:0] low_sat;
		logic [7:0] test1;
		logic [31:0][6:0] table_mem;
		logic transmit_power_enable_meta;
		logic transmit_power_enable_sync;
		logic receive_power_enable_meta;
		logic receive_power_enable_sync;
		logic [5:0] tb_meta;
		logic [5:0] tb_sync;
		logic [4:0] mf_phase;
		logic [31:0] prdata;
		logic pslverr;
		ctagc_pd_type pd;
		logic [5:0] adc_i;
		logic [5:0] adc_q;
		logic [5:0] adc_rf;
		logic [5:0] dac_i;
		logic [5:0] dac_q;
		logic [6:0] rx_dac;
		logic [6:0] tx_dac;
		logic [6:0] acc;
		logic hi_apply;
		logic mid_apply;
		logic low_apply;
		logic div_ok;
		logic [6:0] tbl_rd;
	} ctagc_state_type;

	ctagc_state_type state_r;
	ctagc_state_type state_nxt;
	logic rst_meta_r;
	logic rst_sync_n_r;
	logic [7:0] idx;
	logic aligned;
	logic setup_phase;
	logic wr_access;
	logic [5:0] mux_i;
	logic [5:0] mux_q;
	logic [7:0] wbyte;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	// two-stage release of the async reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// word index and phase terms
	assign idx = apb_req.paddr[9:2];
	assign aligned = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[11:10] == 2'b00);
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign wbyte = apb_req.pwdata[7:0];

	// zero-wait answer; data captured during setup
	assign apb_rsp.pready = apb_req.psel && apb_req.penable;
	assign apb_rsp.prdata = state_r.prdata;
	assign apb_rsp.pslverr = state_r.pslverr && apb_req.psel && apb_req.penable;

	// ----------------------------------------
	// test DAC source
	// ----------------------------------------
	ctagc_dac_mux u_dac_mux (
		.sel(ctagc_sel_type'(state_r.fmt_mux[MUX_LSB +: 3])),
		.lowrate_sel(state_r.test1[LOWRATE_BIT]),
		.taps(taps),
		.adc_i(adc_i_raw),
		.adc_q(adc_q_raw),
		.test_bus(state_r.tb_sync),
		.mf_phase(state_r.mf_phase),
		.dac_i(mux_i),
		.dac_q(mux_q)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;

		// pin synchronisers
		state_nxt.transmit_power_enable_meta = transmit_power_enable;
		state_nxt.transmit_power_enable_sync = state_r.transmit_power_enable_meta;
		state_nxt.receive_power_enable_meta = receive_power_enable;
		state_nxt.receive_power_enable_sync = state_r.receive_power_enable_meta;
		state_nxt.tb_meta = test_bus_in;
		state_nxt.tb_sync = state_r.tb_meta;

		// read capture in setup phase
		if (setup_phase) begin
			state_nxt.prdata = 32'h00000000;
			state_nxt.pslverr = 1'b0;
			if (!aligned) begin
				state_nxt.pslverr = 1'b1;
			end else begin
				unique case (idx)
					IDX_CLK_GATE: state_nxt.prdata[7:0] = state_r.clk_gate;
					IDX_PD_OVR: state_nxt.prdata[7:0] = state_r.pd_ovr;
					IDX_FMT_MUX: state_nxt.prdata[7:0] = state_r.fmt_mux;
					IDX_GAIN_CLIP: state_nxt.prdata[7:0] = state_r.gain_clip;
					IDX_SAT_THR: state_nxt.prdata[7:0] = state_r.sat_thr;
					IDX_RF_PAD: state_nxt.prdata[7:0] = state_r.rf_pad;
					IDX_HI_SAT: state_nxt.prdata[7:0] = state_r.hi_sat;
					IDX_LOCK_IN: state_nxt.prdata[7:0] = state_r.lock_in;
					IDX_LOCK_POS: state_nxt.prdata[7:0] = state_r.lock_pos;
					IDX_BACKOFF: state_nxt.prdata[7:0] = state_r.backoff;
					IDX_TBL_ADDR: state_nxt.prdata[7:0] = state_r.tbl_addr;
					IDX_TBL_DATA: begin
						if (state_r.tbl_addr[TBL_RD_BIT]) begin
							state_nxt.prdata[6:0] = state_r.table_mem[state_r.tbl_addr[4:0]];
						end else begin
							state_nxt.prdata[7:0] = state_r.tbl_data;
						end
					end
					IDX_LOW_SAT: state_nxt.prdata[7:0] = state_r.low_sat;
					IDX_TEST1: state_nxt.prdata[7:0] = state_r.test1;
					default: state_nxt.pslverr = 1'b1;
				endcase
			end
		end

		// register writes at access edge
		if (wr_access && aligned) begin
			unique case (idx)
				IDX_CLK_GATE: state_nxt.clk_gate = wbyte;
				IDX_PD_OVR: state_nxt.pd_ovr = wbyte;
				IDX_FMT_MUX: state_nxt.fmt_mux = wbyte;
				IDX_GAIN_CLIP: state_nxt.gain_clip = wbyte;
				IDX_SAT_THR: state_nxt.sat_thr = wbyte;
				IDX_RF_PAD: state_nxt.rf_pad = wbyte;
				IDX_HI_SAT: state_nxt.hi_sat = wbyte;
				IDX_LOCK_IN: state_nxt.lock_in = wbyte;
				IDX_LOCK_POS: state_nxt.lock_pos = wbyte;
				IDX_BACKOFF: state_nxt.backoff = wbyte;
				IDX_TBL_ADDR: state_nxt.tbl_addr = wbyte;
				IDX_TBL_DATA: begin
					// seven-bit entry, also loads the table when the table-read bit is set
					state_nxt.tbl_data = wbyte;
					if (state_r.tbl_addr[TBL_RD_BIT]) begin
						state_nxt.table_mem[state_r.tbl_addr[4:0]] = wbyte[6:0];
					end
				end
				IDX_LOW_SAT: state_nxt.low_sat = wbyte;
				IDX_TEST1: state_nxt.test1 = wbyte;
				default: state_nxt.pslverr = state_r.pslverr;
			endcase
		end

		if (state_r.pd_ovr[MANUAL_PD_BIT]) begin
			state_nxt.pd = ctagc_pd_type'(state_r.pd_ovr[7:1]);
		end else begin
			state_nxt.pd.standby = 1'b0;
			state_nxt.pd.an_standby = 1'b0;
			state_nxt.pd.transmit_sleep = !state_r.transmit_power_enable_sync;
			state_nxt.pd.an_tx_shutdown = !state_r.transmit_power_enable_sync;
			state_nxt.pd.receive_sleep = !state_r.receive_power_enable_sync;
			state_nxt.pd.an_rx_shutdown = !state_r.receive_power_enable_sync;
			state_nxt.pd.quadrature_sleep = !(state_r.transmit_power_enable_sync || state_r.receive_power_enable_sync);
		end

		if (state_r.fmt_mux[FMT_BIT]) begin
			state_nxt.adc_i = {~adc_i_raw[5], adc_i_raw[4:0]};
			state_nxt.adc_q = {~adc_q_raw[5], adc_q_raw[4:0]};
			state_nxt.adc_rf = {~adc_rf_raw[5], adc_rf_raw[4:0]};
		end else begin
			state_nxt.adc_i = adc_i_raw;
			state_nxt.adc_q = adc_q_raw;
			state_nxt.adc_rf = adc_rf_raw;
		end

		// weight walk, one step per clock
		state_nxt.mf_phase = state_r.mf_phase + 5'd1;
		state_nxt.dac_i = mux_i;
		state_nxt.dac_q = mux_q;

		state_nxt.rx_dac = rx_dac_normal;
		state_nxt.tx_dac = tx_dac_normal;
		if (state_r.fmt_mux[RFADC_DAC_BIT]) begin
			state_nxt.rx_dac = {1'b0, state_r.adc_rf};
		end else if (state_r.fmt_mux[TBUS_DAC_BIT]) begin
			state_nxt.rx_dac = {1'b0, state_r.tb_sync};
			state_nxt.tx_dac = {1'b0, state_r.tb_sync};
		end

		if (atten_req[8]) begin
			state_nxt.acc = 7'h00;
		end else if (atten_req[7:0] > {1'b0, state_r.gain_clip[6:0]}) begin
			state_nxt.acc = state_r.gain_clip[6:0];
		end else begin
			state_nxt.acc = atten_req[6:0];
		end

		state_nxt.mid_apply = sat_count > {1'b0, state_r.sat_thr[7:4]};
		state_nxt.low_apply = sat_count > {1'b0, state_r.sat_thr[3:0]};
		state_nxt.hi_apply = sat_count > {1'b0, state_r.hi_sat[3:0]};
		state_nxt.div_ok = lock_updates <= state_r.lock_pos[7:5];

		// gain table read port
		state_nxt.tbl_rd = state_r.table_mem[table_rd_addr];
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			state_r <= '0;
			state_r.pd <= 7'h7F;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// converter controls
	// ----------------------------------------
	// clock source select
	assign conv_clk_from_serial_pin = state_r.clk_gate[CLK_SRC_BIT];
	assign conv_clk_gate_off = state_r.clk_gate[6:0];
	assign power_down = state_r.pd;
	assign adc_i_out = state_r.adc_i;
	assign adc_q_out = state_r.adc_q;
	assign adc_rf_out = state_r.adc_rf;
	assign iq_dac_i = state_r.dac_i;
	assign iq_dac_q = state_r.dac_q;
	assign rx_dac = state_r.rx_dac;
	assign tx_dac = state_r.tx_dac;
	assign ref_trim_high = state_r.fmt_mux[TRIM_HIGH_BIT];
	assign ref_trim_low = state_r.fmt_mux[TRIM_LOW_BIT];

	// ----------------------------------------
	// test bus pins
	// ----------------------------------------
	// test mode makes pins inputs
	assign test_bus_oe_n = state_r.test1[TEST_IN_BIT];
	assign test_bus_out = test_bus_drive;

	// ----------------------------------------
	// gain set-up outputs
	// ----------------------------------------
	assign agc_cfg.gain_clip = state_r.gain_clip[6:0];
	assign agc_cfg.sat_mid = state_r.sat_thr[7:4];
	assign agc_cfg.sat_low = state_r.sat_thr[3:0];
	assign agc_cfg.rf_pad = state_r.rf_pad[5:0];
	assign agc_cfg.hi_sat_count = state_r.hi_sat[3:0];
	assign agc_cfg.hi_step = {state_r.hi_sat[7:4], 1'b0};
	assign agc_cfg.mid_step = {state_r.low_sat[7:4], 1'b0};
	assign agc_cfg.low_step = state_r.low_sat[3:0];
	assign agc_cfg.tone_scale = state_r.lock_in[7:5];
	assign agc_cfg.tone_force_on = state_r.lock_in[7:5] == 3'h0;
	assign agc_cfg.tone_force_off = state_r.lock_in[7:5] == TONE_OFF_CODE;
	assign agc_cfg.lock_in = state_r.lock_in[4:0];
	assign agc_cfg.max_lock = state_r.lock_pos[7:5];
	assign agc_cfg.lock_pos = state_r.lock_pos[4:0];
	assign agc_cfg.backoff = state_r.backoff[5:0];

	assign atten_acc = state_r.acc;
	assign hi_step_apply = state_r.hi_apply;
	assign mid_step_apply = state_r.mid_apply;
	assign low_step_apply = state_r.low_apply;
	assign diversity_allowed = state_r.div_ok;
	assign table_rd_data = state_r.tbl_rd;
endmodule : ctagc_bank

// ---- ctagc_bank_sva.sv ----
// Purpose: port-level checks of the converter test and gain bank
// Assumes: zero-wait APB slave, registered gain outputs one cycle behind inputs
// Notes: data checks start once reset has fully settled
`timescale 1ns/1ps
module ctagc_bank_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire ctagc_pkg::ctagc_apb_req_type apb_req,
	input wire logic conv_clk_from_serial_pin,
	input wire logic [6:0] conv_clk_gate_off,
	input wire logic ref_trim_high,
	input wire logic ref_trim_low,
	input wire ctagc_pkg::ctagc_agc_cfg_type agc_cfg,
	input wire logic [6:0] atten_acc,
	input wire logic [4:0] sat_count,
	input wire logic [2:0] lock_updates,
	input wire logic hi_step_apply,
	input wire logic diversity_allowed
);
	import ctagc_pkg::*;
	logic [2:0] age_r;
	logic live;
	logic wr_ok;
	// cycles since reset release, saturating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			age_r <= 3'h0;
		end else if (age_r != 3'h7) begin
			age_r <= age_r + 3'h1;
		end
	end
	assign live = (age_r == 3'h7);
	assign wr_ok = apb_req.psel & apb_req.penable & apb_req.pwrite;
	a_clk_src_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_ok && apb_req.paddr == 12'h060 |=> conv_clk_from_serial_pin == $past(apb_req.pwdata[7]))
		else $error("clock source bit not taken from write");
	a_gate_bits_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_ok && apb_req.paddr == 12'h060 |=> conv_clk_gate_off == $past(apb_req.pwdata[6:0]))
		else $error("clock gates not taken from write");
	a_trim_follow: assert property (@(posedge clk) disable iff (!nrst)
		wr_ok && apb_req.paddr == 12'h070 |=> {ref_trim_high, ref_trim_low} == $past(apb_req.pwdata[1:0]))
		else $error("reference trim outputs wrong");
	a_clip_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_ok && apb_req.paddr == 12'h078 |=> agc_cfg.gain_clip == $past(apb_req.pwdata[6:0]))
		else $error("gain clip not taken from write");
	a_acc_clip_upper: assert property (@(posedge clk) disable iff (!nrst)
		live |-> atten_acc <= $past(agc_cfg.gain_clip))
		else $error("attenuator above clip");
	a_hi_step_rule: assert property (@(posedge clk) disable iff (!nrst)
		live |-> hi_step_apply == ($past(sat_count) > $past(agc_cfg.hi_sat_count)))
		else $error("high step apply wrong");
	a_diversity_gate: assert property (@(posedge clk) disable iff (!nrst)
		live |-> diversity_allowed == ($past(lock_updates) <= $past(agc_cfg.max_lock)))
		else $error("diversity allow wrong");
	a_tone_force: assert property (@(posedge clk) disable iff (!nrst)
		wr_ok && apb_req.paddr == 12'h098 |=> agc_cfg.tone_force_on == ($past(apb_req.pwdata[7:5]) == 3'h0)
		&& agc_cfg.tone_force_off == ($past(apb_req.pwdata[7:5]) == TONE_OFF_CODE))
		else $error("tone force flags wrong");
endmodule : ctagc_bank_sva
bind ctagc_bank ctagc_bank_sva u_sva (.clk(clk), .nrst(nrst), .apb_req(apb_req),
	.conv_clk_from_serial_pin(conv_clk_from_serial_pin), .conv_clk_gate_off(conv_clk_gate_off),
	.ref_trim_high(ref_trim_high), .ref_trim_low(ref_trim_low), .agc_cfg(agc_cfg), .atten_acc(atten_acc),
	.sat_count(sat_count), .lock_updates(lock_updates), .hi_step_apply(hi_step_apply),
	.diversity_allowed(diversity_allowed));

// ---- ctagc_bank_tb.sv ----
// Purpose: self-checking bench of the converter test and gain bank
// Assumes: zero-wait APB slave, 10 MHz clock
// Notes: each scenario is a task of its own
`timescale 1ns/1ps
module ctagc_bank_tb;
	import ctagc_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	ctagc_apb_req_type req = '0;
	ctagc_apb_rsp_type rsp;
	ctagc_taps_type taps = {6'h11, 6'h12, 6'h13, 6'h14, 12'hABC, 8'hF0, 8'h0C, {16{8'hFF}}, 6'h07, 6'h05, 6'h06};
	ctagc_pd_type pd;
	ctagc_agc_cfg_type cfg;
	logic tpe = 1'b0, rpe = 1'b0, src, oe_n, trim_h, trim_l, hi_ap, mid_ap, low_ap, div_ok;
	logic [5:0] ai, aq, arf, dac_i, dac_q, ai_out, aq_out, arf_out, tbo;
	logic [8:0] atten_req = '0;
	logic [4:0] sat_count = '0;
	logic [2:0] lock_upd = '0;
	logic [6:0] gate, acc, rxd, txd, trd;
	int err_count = 0;
	int compares = 0;
	localparam logic [14:0] MUX_TBL [6] = '{{3'h0, 12'h452}, {3'h1, 12'h4D4}, {3'h2, 12'h02A},
		{3'h4, 12'hF03}, {3'h6, 12'h659}, {3'h7, 12'h146}};
	localparam logic [27:0] AGC_TBL [4] = '{{9'h050, 5'h05, 3'h3, 11'h20B}, {9'h1FB, 5'h04, 3'h4, 11'h002},
		{9'h011, 5'h06, 3'h0, 11'h11F}, {9'h020, 5'h02, 3'h0, 11'h201}};
	always #50 clk = ~clk;
	ctagc_conv_model u_model (.clk(clk), .nrst(nrst), .adc_i_raw(ai), .adc_q_raw(aq), .adc_rf_raw(arf));
	ctagc_bank dut (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .transmit_power_enable(tpe),
		.receive_power_enable(rpe), .taps(taps), .adc_i_raw(ai), .adc_q_raw(aq), .adc_rf_raw(arf),
		.rx_dac_normal(7'h00), .tx_dac_normal(7'h5A), .test_bus_in(6'h19), .test_bus_drive(6'h2D),
		.atten_req(atten_req), .sat_count(sat_count), .lock_updates(lock_upd), .table_rd_addr(5'h05),
		.conv_clk_from_serial_pin(src), .conv_clk_gate_off(gate), .power_down(pd), .adc_i_out(ai_out),
		.adc_q_out(aq_out), .adc_rf_out(arf_out), .iq_dac_i(dac_i), .iq_dac_q(dac_q), .rx_dac(rxd), .tx_dac(txd),
		.test_bus_out(tbo), .test_bus_oe_n(oe_n), .ref_trim_high(trim_h), .ref_trim_low(trim_l),
		.agc_cfg(cfg), .atten_acc(acc), .hi_step_apply(hi_ap), .mid_step_apply(mid_ap),
		.low_step_apply(low_ap), .diversity_allowed(div_ok), .table_rd_data(trd));
	task automatic summarize;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// one APB transfer, held until pready is sampled high or 20 cycles pass
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [7:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		q = rsp.prdata[7:0];
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20) chk(0, 1, "pready timeout");
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		apb(a, 1'b1, d, q, e);
	endtask : wr
	task automatic t_regs;
		logic [7:0] q;
		logic e;
		for (int i = 0; i < 11; i++) begin
			apb(12'h060 + 12'(8 * i), 1'b0, 8'h00, q, e);
			chk(q, REG_RESET, "reset value");
			wr(12'h060 + 12'(8 * i), 8'hA5 + 8'(i));
			apb(12'h060 + 12'(8 * i), 1'b0, 8'h00, q, e);
			chk(q, 8'hA5 + 8'(i), "readback");
		end
		wr(12'h064, 8'hFF);
		apb(12'h064, 1'b0, 8'h00, q, e);
		chk({q, e}, 9'h001, "unmapped");
	endtask : t_regs
	task automatic t_clk;
		for (int k = 0; k < 2; k++) begin
			wr(12'h060, k ? 8'h7E : 8'h81);
			tick(1);
			chk({src, gate}, k ? 8'h7E : 8'h81, "clock source and gates");
		end
	endtask : t_clk
	task automatic t_power;
		@(posedge clk);
		tpe <= 1'b1;
		rpe <= 1'b1;
		tick(5);
		chk(pd, 7'h00, "auto power both on");
		@(posedge clk);
		rpe <= 1'b0;
		tick(5);
		chk(pd, 7'h12, "auto power tx only");
		wr(12'h068, 8'hAB);
		tick(2);
		chk(pd, 7'h55, "manual power");
		wr(12'h068, 8'h00);
		tick(2);
		chk(pd, 7'h12, "back to auto");
	endtask : t_power
	task automatic t_format;
		logic [5:0] r, p, f, g;
		for (int k = 0; k < 2; k++) begin
			wr(12'h070, k ? 8'hBF : 8'h38);
			@(posedge clk);
			r = ai;
			p = aq;
			f = arf;
			g = arf_out;
			#1;
			chk({ai_out, aq_out, arf_out}, {r, p, f} ^ (k ? 18'h20820 : 18'h00000), "a/d format");
			chk({trim_h, trim_l}, k ? 2'b11 : 2'b00, "trim outputs");
			chk({dac_i, dac_q, rxd, txd}, {r, p, k ? {1'b0, g, 7'h5A} : 14'h0C99}, "dac routing");
		end
	endtask : t_format
	task automatic t_mux;
		logic [5:0] w;
		wr(12'h100, 8'h90);
		foreach (MUX_TBL[k]) begin
			wr(12'h070, {1'b0, MUX_TBL[k][14:12], 4'h0});
			tick(5);
			chk({dac_i, dac_q}, MUX_TBL[k][11:0], "dac source");
		end
		wr(12'h070, 8'h50);
		tick(2);
		w = dac_i;
		tick(1);
		chk({w ^ dac_i, w ^ dac_q}, 12'h7DF, "weights and sync");
		chk({oe_n, tbo}, 7'h6D, "test bus as input");
	endtask : t_mux
	task automatic t_agc;
		wr(12'h078, 8'h20);
		wr(12'h080, 8'h52);
		wr(12'h088, 8'h3F);
		wr(12'h090, 8'hF4);
		wr(12'h098, 8'hF5);
		wr(12'h0A0, 8'h6B);
		wr(12'h0A8, 8'h2B);
		wr(12'h0E0, 8'h97);
		tick(1);
		chk({cfg.rf_pad, cfg.hi_step, cfg.lock_in, cfg.lock_pos, cfg.backoff}, 27'h7FE_AAEB, "gain fields");
		chk({cfg.gain_clip, cfg.sat_mid, cfg.sat_low, cfg.hi_sat_count, cfg.mid_step, cfg.low_step, cfg.max_lock},
			31'h2052493B, "gain counts");
		chk({cfg.tone_force_on, cfg.tone_force_off}, 2'b01, "tone forced off");
		foreach (AGC_TBL[k]) begin
			@(posedge clk);
			atten_req <= AGC_TBL[k][27:19];
			sat_count <= AGC_TBL[k][18:14];
			lock_upd <= AGC_TBL[k][13:11];
			tick(1);
			chk({acc, hi_ap, mid_ap, low_ap, div_ok}, AGC_TBL[k][10:0], "clamp and steps");
		end
		wr(12'h098, 8'h15);
		tick(1);
		chk({cfg.tone_force_on, cfg.tone_force_off}, 2'b10, "tone forced on");
	endtask : t_agc
	task automatic t_table;
		logic [7:0] q;
		logic e;
		wr(12'h0B0, 8'h25);
		wr(12'h0B8, 8'h3C);
		wr(12'h0B0, 8'h05);
		wr(12'h0B8, 8'h81);
		apb(12'h0B8, 1'b0, 8'h00, q, e);
		chk(q, 8'h81, "data register");
		wr(12'h0B0, 8'h25);
		apb(12'h0B8, 1'b0, 8'h00, q, e);
		chk(q, 8'h3C, "table entry");
		chk(trd, 7'h3C, "table read port");
	endtask : t_table
	// main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(posedge clk);
		chk({pd, oe_n}, 8'hFE, "reset state");
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_clk();
		t_power();
		t_format();
		t_mux();
		t_agc();
		t_table();
		summarize();
	end
	// watchdog against a hung handshake
	initial begin
		#(100 * 20000);
		err_count++;
		summarize();
	end
endmodule : ctagc_bank_tb

// ---- ctagc_conv_model.sv ----
// Purpose: converter stand-in feeding A/D samples to the bank
// Assumes: converters run on clk
// Notes: samples change every cycle so a stale value never matches
`timescale 1ns/1ps
module ctagc_conv_model (
	input wire logic clk,
	input wire logic nrst,
	output logic [5:0] adc_i_raw,
	output logic [5:0] adc_q_raw,
	output logic [5:0] adc_rf_raw
);
	logic [5:0] cnt_r;
	// free-running sample pattern
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 6'h15;
		end else begin
			cnt_r <= cnt_r + 6'h07;
		end
	end
	assign adc_i_raw = cnt_r;
	assign adc_q_raw = ~cnt_r;
	assign adc_rf_raw = cnt_r ^ 6'h2A;
endmodule : ctagc_conv_model

// ---- ctagc_dac_mux.sv ----
// Purpose: picks the I/Q test DAC source from the select code
// Assumes: all inputs on clk; output is combinational, registered by the caller
// Notes: matched-filter weights interleave with a sync pulse
`timescale 1ns/1ps
module ctagc_dac_mux (
	input wire ctagc_pkg::ctagc_sel_type sel,
	input wire logic lowrate_sel,
	input wire ctagc_pkg::ctagc_taps_type taps,
	input wire logic [5:0] adc_i,
	input wire logic [5:0] adc_q,
	input wire logic [5:0] test_bus,
	input wire logic [4:0] mf_phase,
	output logic [5:0] dac_i,
	output logic [5:0] dac_q
);
	import ctagc_pkg::*;

	logic [5:0] weight;

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	// upper bits of the current weight
	assign weight = taps.channel_matched_filter[mf_phase[4:1]][7:2];

	// one source per select code
	always_comb begin
		dac_i = taps.tx_filt_i;
		dac_q = taps.tx_filt_q;
		unique case (sel)
			SRC_TX_FILTER: begin
				dac_i = taps.tx_filt_i;
				dac_q = taps.tx_filt_q;
			end
			SRC_DOWNCONV: begin
				dac_i = taps.dconv_i;
				dac_q = taps.dconv_q;
			end
			SRC_CHIP_TIMING: begin
				dac_i = 6'h00;
				dac_q = taps.chip_timing_accumulator[11:6];
			end
			SRC_ADC: begin
				dac_i = adc_i;
				dac_q = adc_q;
			end
			SRC_WINNERS: begin
				dac_i = taps.transform_winner_inphase[7:2];
				dac_q = taps.transform_winner_quadrature[7:2];
			end
			SRC_MF_WEIGHTS: begin
				dac_i = mf_phase[0] ? SYNC_PULSE : weight;
				dac_q = mf_phase[0] ? SYNC_PULSE : weight;
			end
			SRC_TEST_BUS: begin
				dac_i = test_bus;
				dac_q = test_bus;
			end
			SRC_CORR_LOWRATE: begin
				dac_i = lowrate_sel ? taps.lowrate_i : taps.corr_out;
				dac_q = lowrate_sel ? taps.lowrate_q : taps.corr_out;
			end
		endcase
	end
endmodule : ctagc_dac_mux

// ---- ctagc_pkg.sv ----
// Purpose: shared constants and carrier types of the converter test and gain set-up bank
// Assumes: 8-bit registers, each on one aligned 32-bit APB word at byte address 4 * index
// Notes: all registers clear to zero at reset
package ctagc_pkg;
	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_CLK_GATE = 8'h18;
	localparam logic [7:0] IDX_PD_OVR = 8'h1A;
	localparam logic [7:0] IDX_FMT_MUX = 8'h1C;
	localparam logic [7:0] IDX_GAIN_CLIP = 8'h1E;
	localparam logic [7:0] IDX_SAT_THR = 8'h20;
	localparam logic [7:0] IDX_RF_PAD = 8'h22;
	localparam logic [7:0] IDX_HI_SAT = 8'h24;
	localparam logic [7:0] IDX_LOCK_IN = 8'h26;
	localparam logic [7:0] IDX_LOCK_POS = 8'h28;
	localparam logic [7:0] IDX_BACKOFF = 8'h2A;
	localparam logic [7:0] IDX_TBL_ADDR = 8'h2C;
	localparam logic [7:0] IDX_TBL_DATA = 8'h2E;
	localparam logic [7:0] IDX_LOW_SAT = 8'h38;
	localparam logic [7:0] IDX_TEST1 = 8'h40;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CLK_SRC_BIT = 7;
	localparam int MANUAL_PD_BIT = 0;
	localparam int FMT_BIT = 7;
	localparam int MUX_LSB = 4;
	localparam int TBUS_DAC_BIT = 3;
	localparam int RFADC_DAC_BIT = 2;
	localparam int TRIM_HIGH_BIT = 1;
	localparam int TRIM_LOW_BIT = 0;
	localparam int TBL_RD_BIT = 5;
	localparam int TEST_IN_BIT = 4;
	localparam int LOWRATE_BIT = 7;
	localparam logic [2:0] TONE_OFF_CODE = 3'h7;
	localparam logic [5:0] SYNC_PULSE = 6'h20;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRC_TX_FILTER = 3'b000,
		SRC_DOWNCONV = 3'b001,
		SRC_CHIP_TIMING = 3'b010,
		SRC_ADC = 3'b011,
		SRC_WINNERS = 3'b100,
		SRC_MF_WEIGHTS = 3'b101,
		SRC_TEST_BUS = 3'b110,
		SRC_CORR_LOWRATE = 3'b111
	} ctagc_sel_type;
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} ctagc_apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ctagc_apb_rsp_type;
	typedef struct packed {
		logic [5:0] tx_filt_i;
		logic [5:0] tx_filt_q;
		logic [5:0] dconv_i;
		logic [5:0] dconv_q;
		logic [11:0] chip_timing_accumulator;
		logic [7:0] transform_winner_inphase;
		logic [7:0] transform_winner_quadrature;
		logic [15:0][7:0] channel_matched_filter;
		logic [5:0] corr_out;
		logic [5:0] lowrate_i;
		logic [5:0] lowrate_q;
	} ctagc_taps_type;
	typedef struct packed {
		logic standby;
		logic transmit_sleep;
		logic receive_sleep;
		logic quadrature_sleep;
		logic an_tx_shutdown;
		logic an_rx_shutdown;
		logic an_standby;
	} ctagc_pd_type;
	typedef struct packed {
		logic [6:0] gain_clip;
		logic [3:0] sat_mid;
		logic [3:0] sat_low;
		logic [5:0] rf_pad;
		logic [3:0] hi_sat_count;
		logic [4:0] hi_step;
		logic [4:0] mid_step;
		logic [3:0] low_step;
		logic [2:0] tone_scale;
		logic tone_force_on;
		logic tone_force_off;
		logic [4:0] lock_in;
		logic [2:0] max_lock;
		logic [4:0] lock_pos;
		logic [5:0] backoff;
	} ctagc_agc_cfg_type;
endpackage : ctagc_pkg
